// ---- cmad_pkg.sv ----
// Constants for the mixer window access decoder and its link framing.
// Assumes one 50 MHz system clock and a codec that returns the link clock.
package cmad_pkg;

  // ----------------------------------------
  // Host access
  // ----------------------------------------
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int WORD_W = 16;

  localparam logic [1:0] SPACE_IO = 2'h0;
  localparam logic [1:0] SPACE_MEM = 2'h1;
  localparam logic [1:0] SPACE_DMA = 2'h2;

  // ----------------------------------------
  // Window layout
  // ----------------------------------------
  localparam logic [1:0] REGION_PRIMARY = 2'h0;
  localparam logic [1:0] REGION_SECONDARY = 2'h1;
  localparam logic [1:0] REGION_TERTIARY = 2'h2;
  localparam logic [8:0] DMA_LAST = 9'h051;
  localparam logic [1:0] PRIMARY_ID = 2'h0;
  localparam logic [3:0] ID_MAP_RESET = 4'h9;

  // ----------------------------------------
  // Link frame
  // ----------------------------------------
  localparam int TAG_BITS = 16;
  localparam int SLOT_BITS = 20;
  localparam logic [5:0] FRAME_BITS = 6'h38;
  localparam logic [5:0] SLOT2_FIRST = 6'h25;
  localparam logic [15:0] TAG_FRAME_VALID = 16'h8000;
  localparam logic [15:0] TAG_SLOT1_VALID = 16'h4000;
  localparam logic [15:0] TAG_SLOT2_VALID = 16'h2000;

endpackage

// ---- cmad_pin_sync.sv ----
// Three-stage synchroniser with edge pulses for one pin.
// Assumes the pin is asynchronous to clk_sys.
`timescale 1ns/1ps
module cmad_pin_sync (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic pinIn,
  output logic level,
  output logic rise,
  output logic fall
);

  logic stage1_q;
  logic stage2_q;
  logic stage3_q;
  logic level_q;
  logic rise_q;
  logic fall_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
      stage3_q <= 1'b0;
    end else begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  // A change counts once the second and third stages agree
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      level_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if (stage2_q == stage3_q && stage2_q != level_q) begin
        level_q <= stage2_q;
        rise_q <= stage2_q;
        fall_q <= ~stage2_q;
      end
    end
  end

  assign level = level_q;
  assign rise = rise_q;
  assign fall = fall_q;

endmodule

// ---- cmad_access_decode.sv ----
// Mixer window decoder: turns each reachable mixer-space host access into one link word access.
// Assumes the codec drives the link bit clock and answers in the next frame.
`timescale 1ns/1ps
module cmad_access_decode (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic hostReq,
  input wire logic [1:0] hostSpace,
  input wire logic [cmad_pkg::ADDR_W-1:0] hostAddr,
  input wire logic [cmad_pkg::BE_W-1:0] hostByteEn,
  input wire logic hostWrite,
  input wire logic [cmad_pkg::DATA_W-1:0] hostWrData,
  input wire logic [3:0] codecIdMap,
  output logic hostReady,
  output logic hostAck,
  output logic [cmad_pkg::DATA_W-1:0] hostRdData,
  output logic localAccess,
  input wire logic linkBitClk,
  input wire logic linkSdataIn,
  output logic linkSync,
  output logic linkSdataOut
);
  import cmad_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SEND = 4'h2,
    ST_RECV = 4'h4,
    ST_DONE = 4'h8
  } cmad_state_t;

  localparam int FRAME_W = TAG_BITS + 2 * SLOT_BITS;

  // ----------------------------------------
  // Link pin sampling
  // ----------------------------------------
  logic bitRise;
  logic bitFall;
  logic sdiLevel;

  cmad_pin_sync u_bitclk_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pinIn(linkBitClk),
    .level(),
    .rise(bitRise),
    .fall(bitFall)
  );

  cmad_pin_sync u_sdin_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pinIn(linkSdataIn),
    .level(sdiLevel),
    .rise(),
    .fall()
  );

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  logic [1:0] lane;
  logic anyBe;
  logic [8:0] startByte;
  logic [1:0] region;
  logic [1:0] codecId;
  logic [6:0] regIndex;
  logic isMixer;
  logic reachable;
  logic [WORD_W-1:0] wrWord;
  logic take;
  logic [FRAME_W-1:0] cmdFrame;

  always_comb begin
    lane = 2'h0;
    for (int i = BE_W - 1; i >= 0; i--) begin
      if (hostByteEn[i]) begin
        lane = 2'(i);
      end
    end
  end

  assign anyBe = |hostByteEn;
  assign startByte = anyBe ? {hostAddr[8:2], lane} :
                     {hostAddr[8:3], 3'h0};
  assign region = startByte[8:7];
  // Same register layout in every region
  assign regIndex = {startByte[6:1], 1'b0};

  always_comb begin
    case (region)
      REGION_PRIMARY: codecId = PRIMARY_ID;
      REGION_SECONDARY: codecId = codecIdMap[1:0];
      REGION_TERTIARY: codecId = codecIdMap[3:2];
      default: codecId = PRIMARY_ID;
    endcase
  end

  assign isMixer = (hostSpace == SPACE_IO) || (hostSpace == SPACE_MEM);
  assign reachable = (region != 2'h3) &&
                     !(region == REGION_TERTIARY && hostSpace == SPACE_IO);
  assign wrWord = WORD_W'(hostWrData >> {lane, 3'h0});

  // Tag, command slot, data slot
  assign cmdFrame = {TAG_FRAME_VALID | TAG_SLOT1_VALID |
                     (hostWrite ? TAG_SLOT2_VALID : 16'h0000) |
                     {14'h0000, codecId},
                     ~hostWrite, regIndex, 12'h000,
                     hostWrite ? wrWord : 16'h0000, 4'h0};

  cmad_state_t state_q;

  assign hostReady = (state_q == ST_IDLE);
  assign take = hostReq && hostReady;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  logic [5:0] bitCnt_q;
  logic frameEnd;
  logic isRead_q;
  logic [1:0] lane_q;

  assign frameEnd = bitFall && (bitCnt_q == FRAME_BITS);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take && isMixer && reachable) begin
            state_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (frameEnd) begin
            state_q <= isRead_q ? ST_RECV : ST_DONE;
          end
        end
        ST_RECV: begin
          if (frameEnd) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      isRead_q <= 1'b0;
      lane_q <= 2'h0;
    end else if (take) begin
      isRead_q <= ~hostWrite;
      lane_q <= startByte[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bitCnt_q <= 6'h00;
    end else if (state_q != ST_SEND && state_q != ST_RECV) begin
      bitCnt_q <= 6'h00;
    end else if (frameEnd) begin
      bitCnt_q <= 6'h00;
    end else if (bitRise && bitCnt_q != FRAME_BITS) begin
      bitCnt_q <= bitCnt_q + 6'h01;
    end
  end

  // ----------------------------------------
  // Link output, changed on rising bit clock
  // ----------------------------------------
  logic [FRAME_W-1:0] shiftOut_q;
  logic sync_q;
  logic sdo_q;
  logic inFrame;

  assign inFrame = (state_q == ST_SEND) || (state_q == ST_RECV);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      shiftOut_q <= '0;
      sync_q <= 1'b0;
      sdo_q <= 1'b0;
    end else if (take) begin
      shiftOut_q <= cmdFrame;
    end else if (frameEnd && state_q == ST_SEND) begin
      // Empty frame that carries the codec's answer
      shiftOut_q <= {TAG_FRAME_VALID, 40'h0000000000};
    end else if (inFrame && bitRise) begin
      if (bitCnt_q != FRAME_BITS) begin
        sdo_q <= shiftOut_q[FRAME_W-1];
        sync_q <= (bitCnt_q < 6'(TAG_BITS));
        shiftOut_q <= {shiftOut_q[FRAME_W-2:0], 1'b0};
      end else begin
        sdo_q <= 1'b0;
        sync_q <= 1'b0;
      end
    end else if (!inFrame) begin
      sdo_q <= 1'b0;
      sync_q <= 1'b0;
    end
  end

  assign linkSync = sync_q;
  assign linkSdataOut = sdo_q;

  // ----------------------------------------
  // Answer capture, on falling bit clock
  // ----------------------------------------
  logic [SLOT_BITS-1:0] capture_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      capture_q <= '0;
    end else if (state_q == ST_RECV && bitFall &&
                 bitCnt_q >= SLOT2_FIRST) begin
      capture_q <= {capture_q[SLOT_BITS-2:0], sdiLevel};
    end
  end

  // ----------------------------------------
  // Host answer
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hostAck <= 1'b0;
      hostRdData <= '0;
      localAccess <= 1'b0;
    end else begin
      hostAck <= 1'b0;
      localAccess <= 1'b0;
      if (take && !isMixer) begin
        hostAck <= 1'b1;
        hostRdData <= '0;
        localAccess <= (hostSpace == SPACE_DMA) &&
                       (hostAddr <= DMA_LAST);
      end else if (take && !reachable) begin
        hostAck <= 1'b1;
        hostRdData <= '1;
      end else if (state_q == ST_DONE) begin
        hostAck <= 1'b1;
        hostRdData <= isRead_q ?
          DATA_W'(capture_q[SLOT_BITS-1:4]) << {lane_q, 3'h0} :
          '0;
      end
    end
  end

endmodule

// ---- cmad_asserts.sv ----
// Checker of host handshake and link frame timing.
// Assumes it is bound into cmad_access_decode.
`timescale 1ns/1ps
module cmad_asserts (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic hostReq,
  input wire logic [1:0] hostSpace,
  input wire logic [cmad_pkg::ADDR_W-1:0] hostAddr,
  input wire logic hostWrite,
  input wire logic hostReady,
  input wire logic hostAck,
  input wire logic [cmad_pkg::DATA_W-1:0] hostRdData,
  input wire logic localAccess,
  input wire logic linkSync
);
  import cmad_pkg::*;
  wire take = hostReq && hostReady;
  wire dma = take && hostSpace == SPACE_DMA;
  wire tertIo = take && hostSpace == SPACE_IO && hostAddr[8:7] == 2'h2;
  wire link = take && !hostSpace[1] && hostAddr[8:7] != 2'h3 && !tertIo;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_local;
    dma && hostAddr <= DMA_LAST |=> hostAck && localAccess && hostReady;
  endproperty
  a_local: assert property (p_local) else $error("no local ack");
  property p_noLink;
    dma |=> !linkSync [*8];
  endproperty
  a_noLink: assert property (p_noLink) else $error("dma framed");
  property p_tert;
    tertIo && !hostWrite |=> hostAck && hostRdData == 32'hFFFFFFFF;
  endproperty
  a_tert: assert property (p_tert) else $error("io tertiary");
  property p_link;
    link |=> !hostReady ##[0:40] $rose(linkSync);
  endproperty
  a_link: assert property (p_link) else $error("no frame");
  property p_tag;
    $rose(linkSync) |-> ##120 linkSync ##[1:16] !linkSync;
  endproperty
  a_tag: assert property (p_tag) else $error("tag length");
  property p_ackOnce;
    hostAck && !take |=> !hostAck;
  endproperty
  a_ackOnce: assert property (p_ackOnce) else $error("long ack");
  property p_hold;
    !hostAck |-> $stable(hostRdData);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_localAck;
    localAccess |-> hostAck;
  endproperty
  a_localAck: assert property (p_localAck) else $error("lone local");
  c_read: cover property (link && !hostWrite);
  c_local: cover property (localAccess);
  c_tert: cover property (tertIo);
endmodule
bind cmad_access_decode cmad_asserts u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .hostReq(hostReq),
  .hostSpace(hostSpace), .hostAddr(hostAddr), .hostWrite(hostWrite),
  .hostReady(hostReady), .hostAck(hostAck), .hostRdData(hostRdData),
  .localAccess(localAccess), .linkSync(linkSync));

// ---- cmad_codec_model.sv ----
// Codec model: bit clock, frame capture and read answer.
// Assumes link outputs settle before the next bit clock rise.
`timescale 1ns/1ps
module cmad_codec_model (
  input wire logic linkSync,
  input wire logic linkSdataOut,
  output logic linkBitClk,
  output logic linkSdataIn,
  output logic [55:0] lastReq,
  output logic [7:0] reqCnt
);
  logic [55:0] fr;
  logic [15:0] w;
  logic seen;
  int pos;
  assign w = {lastReq[38:32], 1'h1, lastReq[41:40], 6'h2A};
  initial begin
    {linkBitClk, linkSdataIn, seen, fr, lastReq, reqCnt} = '0;
    pos = 56;
    #37;
    forever #80 linkBitClk = ~linkBitClk;
  end
  // Answer word follows index and id of the last request
  always @(posedge linkBitClk) begin
    if (linkSync && !seen) pos = 0;
    if (pos < 56) fr[55-pos] = linkSdataOut;
    if (pos == 55 && fr[54]) begin
      lastReq = fr;
      reqCnt = reqCnt + 8'h01;
    end
    if (pos < 56) pos++;
    if (pos >= 36 && pos <= 51) linkSdataIn = w[51-pos];
    else linkSdataIn = ~linkSdataIn;
    seen = linkSync;
  end
endmodule

// ---- codec_mixer_access_decode_tb_top.sv ----
// Table-driven bench of the mixer window decoder.
// Assumes the behavioural codec model on the link side.
`timescale 1ns/1ps
module codec_mixer_access_decode_tb_top;
  import cmad_pkg::*;
  typedef struct packed {
    logic [1:0] sp;
    logic [8:0] ad;
    logic [3:0] be;
    logic wr;
    logic [31:0] wd;
    logic lk;
    logic lc;
    logic [1:0] id;
    logic [6:0] ix;
    logic [31:0] ed;
  } cmad_row_t;
  localparam cmad_row_t ROWS [9] = '{
    '{2'h0,9'h002,4'hC,1'h1,32'h12340000,1'h1,1'h0,2'h0,7'h02,32'h1234},
    '{2'h1,9'h10C,4'h0,1'h1,32'h12345A5A,1'h1,1'h0,2'h2,7'h08,32'h5A5A},
    '{2'h0,9'h104,4'h3,1'h0,32'h0,1'h0,1'h0,2'h0,7'h00,32'hFFFFFFFF},
    '{2'h2,9'h050,4'h2,1'h0,32'h0,1'h0,1'h1,2'h0,7'h00,32'h0},
    '{2'h2,9'h054,4'h1,1'h0,32'h0,1'h0,1'h0,2'h0,7'h00,32'h0},
    '{2'h3,9'h000,4'h1,1'h0,32'h0,1'h0,1'h0,2'h0,7'h00,32'h0},
    '{2'h1,9'h184,4'h3,1'h0,32'h0,1'h0,1'h0,2'h0,7'h00,32'hFFFFFFFF},
    '{2'h0,9'h07C,4'hC,1'h0,32'h0,1'h1,1'h0,2'h0,7'h7E,32'hFD2A0000},
    '{2'h0,9'h0A4,4'h2,1'h0,32'h0,1'h1,1'h0,2'h1,7'h24,32'h496A00}};
  logic clk_sys, sys_rst, hostReq, hostWrite, hostReady, hostAck;
  logic localAccess, linkBitClk, linkSdataIn, linkSync, linkSdataOut;
  logic gotLc;
  logic [1:0] hostSpace;
  logic [8:0] hostAddr;
  logic [3:0] hostByteEn, codecIdMap;
  logic [31:0] hostWrData, hostRdData, gotRd;
  logic [55:0] lastReq, ef;
  logic [7:0] reqCnt, n;
  cmad_row_t r;
  int fails, comparisons;
  cmad_access_decode dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .hostReq(hostReq), .hostSpace(hostSpace), .hostAddr(hostAddr),
    .hostByteEn(hostByteEn), .hostWrite(hostWrite),
    .hostWrData(hostWrData), .codecIdMap(codecIdMap),
    .hostReady(hostReady), .hostAck(hostAck), .hostRdData(hostRdData),
    .localAccess(localAccess), .linkBitClk(linkBitClk),
    .linkSdataIn(linkSdataIn), .linkSync(linkSync),
    .linkSdataOut(linkSdataOut));
  cmad_codec_model codec (.linkSync(linkSync), .linkSdataOut(linkSdataOut),
    .linkBitClk(linkBitClk), .linkSdataIn(linkSdataIn),
    .lastReq(lastReq), .reqCnt(reqCnt));
  task automatic chk(input logic [55:0] got, input logic [55:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // One access, held until taken, then wait for its ack
  task automatic acc(input logic [1:0] sp, input logic [8:0] ad,
      input logic [3:0] be, input logic wr, input logic [31:0] wd);
    int k;
    @(negedge clk_sys);
    {hostReq, hostSpace, hostAddr, hostByteEn} = {1'h1, sp, ad, be};
    {hostWrite, hostWrData} = {wr, wd};
    // Ready is settled at the falling edge; the next rising edge takes it
    while (hostReady !== 1'h1) @(negedge clk_sys);
    @(negedge clk_sys);
    hostReq = 1'h0;
    for (k = 0; k < 5000 && hostAck !== 1'h1; k++) @(negedge clk_sys);
    if (k == 5000) fails++;
    {gotRd, gotLc} = {hostRdData, localAccess};
    repeat (20) @(negedge clk_sys);
  endtask
  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    fails++;
    stop_test();
  end
  initial begin
    {hostReq, hostSpace, hostAddr, hostByteEn} = '0;
    {hostWrite, hostWrData, codecIdMap, sys_rst} = {37'h9, 1'h1};
    repeat (16) @(negedge clk_sys);
    sys_rst = 1'h0;
    foreach (ROWS[i]) begin
      r = ROWS[i];
      n = reqCnt;
      acc(r.sp, r.ad, r.be, r.wr, r.wd);
      ef = {2'h3, r.wr, 11'h0, r.id, ~r.wr, r.ix, 12'h0, r.ed[15:0], 4'h0};
      if (!r.wr) ef[19:0] = 20'h0;
      chk(gotLc, r.lc);
      if (!r.wr) chk(gotRd, r.ed);
      chk(reqCnt - n, r.lk);
      if (r.lk) chk(lastReq, ef);
      $display("row %0d done", i);
    end
    codecIdMap = 4'h6;
    for (int j = 0; j < 3; j++) begin
      acc(2'h1, 9'(j * 128), 4'h3, 1'h1, 32'h0);
      chk(lastReq[41:40], j == 0 ? 2'h0 : codecIdMap[2*j-1 -: 2]);
    end
    $display("remap done");
    @(negedge clk_sys);
    hostReq = 1'h1;
    @(negedge clk_sys);
    hostReq = 1'h0;
    repeat (50) @(negedge clk_sys);
    sys_rst = 1'h1;
    repeat (4) @(negedge clk_sys);
    chk({hostReady, hostAck, localAccess, linkSync, linkSdataOut,
      hostRdData}, {5'h10, 32'h0});
    sys_rst = 1'h0;
    acc(2'h2, 9'h000, 4'h1, 1'h0, 32'h0);
    chk(gotLc, 1'h1);
    $display("reset done");
    stop_test();
  end
endmodule
